// File: hw/sssr_group.v
`timescale 1ns/1ps
`include "sssr_map.vh"

// one status group: condition, latching event and enable mask
module sssr_group #(
  parameter WIDTH = 16                          // bits in this group
) (
  input  wire             mclk_i,               // system clock
  input  wire             rst_i,                // async reset, high
  input  wire [WIDTH-1:0] cond_i,               // live instrument state
  input  wire             evt_rd_i,             // event query, clears after read
  input  wire             cls_i,                // clear-status command
  input  wire             preset_i,             // status preset command
  input  wire             ena_wr_i,             // enable mask write strobe
  input  wire [WIDTH-1:0] ena_data_i,           // enable mask write value
  output wire [WIDTH-1:0] cond_o,               // condition view
  output wire [WIDTH-1:0] event_o,              // event register
  output wire [WIDTH-1:0] enable_o,             // enable register
  output wire             summary_o             // enabled summary bit
);

  reg [WIDTH-1:0] cond_prev_q;                  // condition one cycle ago
  reg [WIDTH-1:0] event_q;                      // latched events
  reg [WIDTH-1:0] event_d;                      // next events
  reg [WIDTH-1:0] enable_q;                     // enable mask
  wire [WIDTH-1:0] rise;                        // fresh occurrences

  // condition passes straight through, never latched nor altered by reads
  assign cond_o = cond_i;
  assign rise   = cond_i & ~cond_prev_q;

  // ****************************************************************
  // event latch
  // ****************************************************************
  // a set in the same cycle as a clear survives, so no event is lost
  always @* begin
    event_d = event_q;
    if (evt_rd_i || cls_i) begin
      event_d = {WIDTH{1'b0}};
    end
    event_d = event_d | rise;
  end

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cond_prev_q <= {WIDTH{1'b0}};
      event_q     <= {WIDTH{1'b0}};
    end else begin
      cond_prev_q <= cond_i;
      event_q     <= event_d;
    end
  end

  // ****************************************************************
  // enable mask
  // ****************************************************************
  // preset wins over a write in the same cycle; clear-status leaves it
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_q <= {WIDTH{1'b0}};
    end else if (preset_i) begin
      enable_q <= {WIDTH{1'b0}};
    end else if (ena_wr_i) begin
      enable_q <= ena_data_i;
    end
  end

  assign event_o   = event_q;
  assign enable_o  = enable_q;
  // dropping event bits drops this summary at once
  assign summary_o = |(event_q & enable_q);

endmodule // sssr_group

// File: hw/sssr_map.vh
`ifndef SSSR_MAP_VH
`define SSSR_MAP_VH

// ****************************************************************
// command codes on cmd_code_i
// ****************************************************************
`define SSSR_CMD_CLS      4'h0
`define SSSR_CMD_PRESET   4'h1
`define SSSR_CMD_SRE_WR   4'h2
`define SSSR_CMD_PSC_WR   4'h3
`define SSSR_CMD_ENA_WR   4'h4
`define SSSR_CMD_COND_RD  4'h5
`define SSSR_CMD_EVT_RD   4'h6
`define SSSR_CMD_ENA_RD   4'h7
`define SSSR_CMD_STB_RD   4'h8
`define SSSR_CMD_SRE_RD   4'h9
`define SSSR_CMD_PSC_RD   4'ha

// ****************************************************************
// group select on cmd_grp_i
// ****************************************************************
`define SSSR_GRP_ALARM    2'h0
`define SSSR_GRP_QUES     2'h1
`define SSSR_GRP_STD      2'h2
`define SSSR_GRP_OPER     2'h3

// ****************************************************************
// summary byte bit positions
// ****************************************************************
`define SSSR_STB_ALARM    1
`define SSSR_STB_QUES     3
`define SSSR_STB_MAV      4
`define SSSR_STB_STD      5
`define SSSR_STB_RQS      6
`define SSSR_STB_OPER     7

// ****************************************************************
// reset values
// ****************************************************************
`define SSSR_SRE_RST      8'h00
`define SSSR_ENA_RST      16'h0000

`endif

// File: hw/sssr_rqs.v
`timescale 1ns/1ps
`include "sssr_map.vh"

// master summary and service request latch
module sssr_rqs (
  input  wire       mclk_i,                     // system clock
  input  wire       rst_i,                      // async reset, high
  input  wire [7:0] stb_i,                      // summary byte, bit 6 ignored
  input  wire [7:0] sre_i,                      // summary enable mask
  input  wire       spoll_i,                    // serial poll strobe
  output wire       mss_o,                      // master summary level
  output wire       rqs_o                       // request service / srq line
);

  reg  mss_prev_q;                              // master summary last cycle
  reg  rqs_q;                                   // request latch
  wire [7:0] masked;                            // enabled summary bits

  // bit 6 of the mask is meaningless, it would feed back on itself
  assign masked = stb_i & sre_i & 8'hbf;
  assign mss_o  = |masked;

  // ****************************************************************
  // request latch
  // ****************************************************************
  // set on 0->1 of the master summary; a poll clears only this bit;
  // a rise in the poll cycle keeps the request up
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mss_prev_q <= 1'b0;
      rqs_q      <= 1'b0;
    end else begin
      mss_prev_q <= mss_o;
      if (mss_o && !mss_prev_q) begin
        rqs_q <= 1'b1;
      end else if (spoll_i) begin
        rqs_q <= 1'b0;
      end
    end
  end

  assign rqs_o = rqs_q;

endmodule // sssr_rqs

// File: hw/sssr_top.v
`timescale 1ns/1ps
`include "sssr_map.vh"

// Overview of operation
// - four groups: condition, event, enable each
// - condition follows state, read-only, read-safe
// - event bit latches once, repeats ignored
// - event cleared by query or clear-status only
// - queries return binary-weighted register value
// - enable masks readable, writable, gate summaries
// - clear-status clears events, keeps enables
// - preset clears every group enable register, summary mask kept
// - message-available follows output buffer data
// - clearing events clears matching summary bit
// - summary weights 2, 8, 32, 128; 0,2 zero
// - master bit set when enabled summaries set
// - mask clears on zero write, power-on flag
// - master bit rising raises service request
// - serial poll clears only request bit
// - serial poll served immediately, never queued
// - summary query same byte, waits, no clear

module sssr_top #(
  parameter ALM_W  = 16,                        // alarm group width
  parameter QUES_W = 16,                        // questionable group width
  parameter STD_W  = 8,                         // standard event width
  parameter OPER_W = 16                         // standard operation width
) (
  input  wire        mclk_i,                    // system clock, 20 MHz
  input  wire        rst_i,                     // power-on reset, async, high
  input  wire [15:0] alm_cond_i,                // alarm conditions
  input  wire [15:0] ques_cond_i,               // questionable conditions
  input  wire [15:0] std_cond_i,                // standard event conditions
  input  wire [15:0] oper_cond_i,               // operation conditions
  input  wire        mav_i,                     // output buffer holds data
  input  wire        cmd_busy_i,                // earlier commands still running
  input  wire        cmd_valid_i,               // command strobe
  input  wire [3:0]  cmd_code_i,                // command code
  input  wire [1:0]  cmd_grp_i,                 // target group
  input  wire [15:0] cmd_data_i,                // write value
  input  wire        spoll_i,                   // serial poll strobe
  input  wire        nv_psc_i,                  // stored power-on-clear flag
  input  wire [7:0]  nv_sre_i,                  // stored summary enable mask
  output wire        cmd_ready_o,               // command accepted when high
  output reg         rsp_valid_o,               // query answer pulse
  output reg  [15:0] rsp_data_o,                // query answer value
  output reg         spoll_valid_o,             // poll answer pulse
  output reg  [7:0]  spoll_data_o,              // poll answer byte
  output wire        srq_o,                     // service request line
  output wire        psc_o,                     // power-on-clear flag to store
  output wire [7:0]  sre_o                      // summary mask to store
);

  // ****************************************************************
  // command decode
  // ****************************************************************
  wire        take;                             // command taken this cycle
  wire        do_cls;                           // clear-status
  wire        do_preset;                        // status preset
  wire        do_ena_wr;                        // group enable write
  wire        do_evt_rd;                        // group event query
  wire [3:0]  grp_hit;                          // one-hot group select
  reg         stb_pend_q;                       // summary query waiting
  reg         por_load_q;                       // load pending after reset
  reg         psc_q;                            // power-on-clear flag
  reg  [7:0]  sre_q;                            // summary enable mask

  // a pending summary query stalls new commands so order is kept
  assign cmd_ready_o = !stb_pend_q;
  assign take        = cmd_valid_i && cmd_ready_o;
  assign do_cls      = take && (cmd_code_i == `SSSR_CMD_CLS);
  assign do_preset   = take && (cmd_code_i == `SSSR_CMD_PRESET);
  assign do_ena_wr   = take && (cmd_code_i == `SSSR_CMD_ENA_WR);
  assign do_evt_rd   = take && (cmd_code_i == `SSSR_CMD_EVT_RD);

  // one-hot select of a group index
  function [3:0] grp_dec;
    input [1:0] g;
    begin
      grp_dec = 4'h1 << g;
    end
  endfunction

  assign grp_hit = grp_dec(cmd_grp_i);

  // ****************************************************************
  // status groups
  // ****************************************************************
  wire [ALM_W-1:0]  alm_cond;                   // alarm condition view
  wire [ALM_W-1:0]  alm_evt;                    // alarm events
  wire [ALM_W-1:0]  alm_ena;                    // alarm mask
  wire              alm_sum;                    // alarm summary
  wire [QUES_W-1:0] ques_cond;                  // questionable condition view
  wire [QUES_W-1:0] ques_evt;                   // questionable events
  wire [QUES_W-1:0] ques_ena;                   // questionable mask
  wire              ques_sum;                   // questionable summary
  wire [STD_W-1:0]  std_cond;                   // standard condition view
  wire [STD_W-1:0]  std_evt;                    // standard events
  wire [STD_W-1:0]  std_ena;                    // standard mask
  wire              std_sum;                    // standard summary
  wire [OPER_W-1:0] oper_cond;                  // operation condition view
  wire [OPER_W-1:0] oper_evt;                   // operation events
  wire [OPER_W-1:0] oper_ena;                   // operation mask
  wire              oper_sum;                   // operation summary

  sssr_group #(.WIDTH(ALM_W)) u_alm (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .cond_i     (alm_cond_i[ALM_W-1:0]),
    .evt_rd_i   (do_evt_rd && grp_hit[`SSSR_GRP_ALARM]),
    .cls_i      (do_cls),
    .preset_i   (do_preset),
    .ena_wr_i   (do_ena_wr && grp_hit[`SSSR_GRP_ALARM]),
    .ena_data_i (cmd_data_i[ALM_W-1:0]),
    .cond_o     (alm_cond),
    .event_o    (alm_evt),
    .enable_o   (alm_ena),
    .summary_o  (alm_sum)
  );

  sssr_group #(.WIDTH(QUES_W)) u_ques (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .cond_i     (ques_cond_i[QUES_W-1:0]),
    .evt_rd_i   (do_evt_rd && grp_hit[`SSSR_GRP_QUES]),
    .cls_i      (do_cls),
    .preset_i   (do_preset),
    .ena_wr_i   (do_ena_wr && grp_hit[`SSSR_GRP_QUES]),
    .ena_data_i (cmd_data_i[QUES_W-1:0]),
    .cond_o     (ques_cond),
    .event_o    (ques_evt),
    .enable_o   (ques_ena),
    .summary_o  (ques_sum)
  );

  sssr_group #(.WIDTH(STD_W)) u_std (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .cond_i     (std_cond_i[STD_W-1:0]),
    .evt_rd_i   (do_evt_rd && grp_hit[`SSSR_GRP_STD]),
    .cls_i      (do_cls),
    .preset_i   (do_preset),
    .ena_wr_i   (do_ena_wr && grp_hit[`SSSR_GRP_STD]),
    .ena_data_i (cmd_data_i[STD_W-1:0]),
    .cond_o     (std_cond),
    .event_o    (std_evt),
    .enable_o   (std_ena),
    .summary_o  (std_sum)
  );

  sssr_group #(.WIDTH(OPER_W)) u_oper (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .cond_i     (oper_cond_i[OPER_W-1:0]),
    .evt_rd_i   (do_evt_rd && grp_hit[`SSSR_GRP_OPER]),
    .cls_i      (do_cls),
    .preset_i   (do_preset),
    .ena_wr_i   (do_ena_wr && grp_hit[`SSSR_GRP_OPER]),
    .ena_data_i (cmd_data_i[OPER_W-1:0]),
    .cond_o     (oper_cond),
    .event_o    (oper_evt),
    .enable_o   (oper_ena),
    .summary_o  (oper_sum)
  );

  // ****************************************************************
  // summary byte and service request
  // ****************************************************************
  wire [7:0] stb_cond;                          // summary byte without bit 6
  wire       mss;                               // master summary level
  wire       rqs;                               // latched request

  // bits 0 and 2 are tied low; group summaries at fixed weights;
  // message-available tracks the output buffer directly
  assign stb_cond = {oper_sum, 1'b0, std_sum, mav_i,
                     ques_sum, 1'b0, alm_sum, 1'b0};

  sssr_rqs u_rqs (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .stb_i   (stb_cond),
    .sre_i   (sre_q),
    .spoll_i (spoll_i),
    .mss_o   (mss),
    .rqs_o   (rqs)
  );

  assign srq_o = rqs;

  // ****************************************************************
  // power-on flag and summary enable mask
  // ****************************************************************
  // async reset can only load constants, so the stored flag and mask
  // are taken on the first edge after release
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      por_load_q <= 1'b1;
      psc_q      <= 1'b0;
      sre_q      <= `SSSR_SRE_RST;
    end else if (por_load_q) begin
      por_load_q <= 1'b0;
      psc_q      <= nv_psc_i;
      // flag set: power-on clears the mask; flag clear: mask retained
      sre_q      <= nv_psc_i ? `SSSR_SRE_RST : nv_sre_i;
    end else if (take && cmd_code_i == `SSSR_CMD_SRE_WR) begin
      sre_q      <= cmd_data_i[7:0];
    end else if (take && cmd_code_i == `SSSR_CMD_PSC_WR) begin
      psc_q      <= |cmd_data_i;
    end
  end

  assign psc_o = psc_q;
  assign sre_o = sre_q;

  // ****************************************************************
  // query answers
  // ****************************************************************
  // select the addressed group register for the answer bus
  function [15:0] grp_sel;
    input [1:0]  g;
    input [15:0] a;
    input [15:0] q;
    input [15:0] s;
    input [15:0] o;
    begin
      case (g)
        `SSSR_GRP_ALARM: grp_sel = a;
        `SSSR_GRP_QUES:  grp_sel = q;
        `SSSR_GRP_STD:   grp_sel = s;
        default:         grp_sel = o;
      endcase
    end
  endfunction

  wire [15:0] cond_sel;                         // selected condition value
  wire [15:0] evt_sel;                          // selected event value
  wire [15:0] ena_sel;                          // selected mask value

  assign cond_sel = grp_sel(cmd_grp_i, {{(16-ALM_W){1'b0}}, alm_cond},
                            {{(16-QUES_W){1'b0}}, ques_cond},
                            {{(16-STD_W){1'b0}}, std_cond},
                            {{(16-OPER_W){1'b0}}, oper_cond});
  assign evt_sel  = grp_sel(cmd_grp_i, {{(16-ALM_W){1'b0}}, alm_evt},
                            {{(16-QUES_W){1'b0}}, ques_evt},
                            {{(16-STD_W){1'b0}}, std_evt},
                            {{(16-OPER_W){1'b0}}, oper_evt});
  assign ena_sel  = grp_sel(cmd_grp_i, {{(16-ALM_W){1'b0}}, alm_ena},
                            {{(16-QUES_W){1'b0}}, ques_ena},
                            {{(16-STD_W){1'b0}}, std_ena},
                            {{(16-OPER_W){1'b0}}, oper_ena});

  // summary query waits for earlier commands; while waiting new
  // commands stall, the poll path does not
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      stb_pend_q  <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= 16'h0000;
    end else begin
      rsp_valid_o <= 1'b0;
      if (stb_pend_q) begin
        if (!cmd_busy_i) begin
          // same byte as a poll but bit 6 is the live master summary
          stb_pend_q  <= 1'b0;
          rsp_valid_o <= 1'b1;
          rsp_data_o  <= {8'h00, stb_cond[7], mss, stb_cond[5:0]};
        end
      end else if (take) begin
        case (cmd_code_i)
          `SSSR_CMD_COND_RD: begin
            rsp_valid_o <= 1'b1;
            rsp_data_o  <= cond_sel;
          end
          `SSSR_CMD_EVT_RD: begin
            // value taken before the clear lands on the next edge
            rsp_valid_o <= 1'b1;
            rsp_data_o  <= evt_sel;
          end
          `SSSR_CMD_ENA_RD: begin
            rsp_valid_o <= 1'b1;
            rsp_data_o  <= ena_sel;
          end
          `SSSR_CMD_STB_RD: begin
            if (cmd_busy_i) begin
              stb_pend_q <= 1'b1;
            end else begin
              rsp_valid_o <= 1'b1;
              rsp_data_o  <= {8'h00, stb_cond[7], mss, stb_cond[5:0]};
            end
          end
          `SSSR_CMD_SRE_RD: begin
            rsp_valid_o <= 1'b1;
            rsp_data_o  <= {8'h00, sre_q};
          end
          `SSSR_CMD_PSC_RD: begin
            rsp_valid_o <= 1'b1;
            rsp_data_o  <= {15'h0000, psc_q};
          end
          default: begin
            rsp_valid_o <= 1'b0;                // writes give no answer
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // serial poll
  // ****************************************************************
  // answered on the next edge regardless of busy or pending commands;
  // bit 6 shows the latched request, cleared in the same edge
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      spoll_valid_o <= 1'b0;
      spoll_data_o  <= 8'h00;
    end else begin
      spoll_valid_o <= spoll_i;
      if (spoll_i) begin
        spoll_data_o <= {stb_cond[7], rqs, stb_cond[5:0]};
      end
    end
  end

endmodule // sssr_top

// File: verification/sssr_ctl_model.sv
`timescale 1ns/1ps
// ****************************************
// bus controller model
// ****************************************
module sssr_ctl_model (
  input  logic        mclk_i, cmd_ready_i, rsp_valid_i, spoll_valid_i,
  input  logic [15:0] rsp_data_i,
  input  logic [7:0]  spoll_data_i,
  output logic        cmd_valid_o = 1'b0, spoll_o = 1'b0,
  output logic [3:0]  cmd_code_o = 4'h0,
  output logic [1:0]  cmd_grp_o = 2'h0,
  output logic [15:0] cmd_data_o = 16'h0000
);
  // hold the command until taken, then wait a bounded time for the answer
  task cmd(input logic [3:0] c, input logic [1:0] g, input logic [15:0] d,
           output logic [15:0] r, output logic got);
    int   n;
    logic rdy;
    @(posedge mclk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_code_o  = c;
    cmd_grp_o   = g;
    cmd_data_o  = d;
    // ready only moves on an edge, so read just after one it shows what the next edge sees
    rdy = cmd_ready_i;
    while (!rdy) begin
      @(posedge mclk_i);
      #1;
      rdy = cmd_ready_i;
    end
    @(posedge mclk_i);
    #1;
    cmd_valid_o = 1'b0;
    cmd_code_o  = ~c;  // idle fields toggle so stale values never look valid
    cmd_data_o  = ~d;
    got = 1'b0;
    r   = 16'hxxxx;  // a missing answer never matches an expected value
    n   = 0;
    while (!got && n < 20) begin
      if (rsp_valid_i) begin
        got = 1'b1;
        r   = rsp_data_i;
      end else begin
        @(posedge mclk_i);
        #1;
        n++;
      end
    end
  endtask

  // serial poll, answered next cycle; no answer shows as unknown
  task poll(output logic [7:0] b);
    @(posedge mclk_i);
    #1 spoll_o = 1'b1;
    @(posedge mclk_i);
    #1 spoll_o = 1'b0;
    b = spoll_valid_i ? spoll_data_i : 8'hxx;
  endtask
endmodule // sssr_ctl_model

// File: verification/sssr_tb_top.sv
`timescale 1ns/1ps
// ****************************************
// status summary bench
// ****************************************
module sssr_tb_top;
  logic        mclk_i = 1'b0, rst_i = 1'b1, mav_i = 1'b0, cmd_busy_i = 1'b0, nv_psc_i = 1'b0;
  logic [15:0] alm = 16'h0000, ques = 16'h0000, std = 16'h0000, oper = 16'h0000, r;
  logic [7:0]  nv_sre_i = 8'h00, b, spoll_data_o, sre_o;
  logic        cmd_valid_i, spoll_i, cmd_ready_o, rsp_valid_o, spoll_valid_o, srq_o, psc_o, got;
  logic [3:0]  cmd_code_i;
  logic [1:0]  cmd_grp_i;
  logic [15:0] cmd_data_i, rsp_data_o;
  int          mismatches = 0, samples_checked = 0, cyc = 0;
  // rows: code, group, write value, expected answer
  logic [39:0] rows [25] = '{40'h5_0_0000_0003, 40'h5_1_0000_0201, 40'h5_2_0000_0024,
    40'h5_3_0000_8001, 40'h5_1_0000_0201, 40'h4_1_0200_0000, 40'h7_1_0000_0200,
    40'h2_0_0008_0000, 40'h9_0_0000_0008, 40'h8_0_0000_0048, 40'h6_1_0000_0201,
    40'h6_1_0000_0000, 40'h8_0_0000_0000, 40'h4_0_0003_0000, 40'h4_2_0024_0000,
    40'h4_3_8000_0000, 40'h8_0_0000_00a2, 40'h0_0_0000_0000, 40'h8_0_0000_0000,
    40'h7_0_0000_0003, 40'h1_0_0000_0000, 40'h7_3_0000_0000, 40'h3_0_0005_0000,
    40'ha_0_0000_0001, 40'h6_3_0000_0000};

  always #25 mclk_i = ~mclk_i;

  sssr_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .alm_cond_i(alm), .ques_cond_i(ques),
    .std_cond_i(std), .oper_cond_i(oper), .mav_i(mav_i), .cmd_busy_i(cmd_busy_i),
    .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_grp_i(cmd_grp_i),
    .cmd_data_i(cmd_data_i), .spoll_i(spoll_i), .nv_psc_i(nv_psc_i), .nv_sre_i(nv_sre_i),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .spoll_valid_o(spoll_valid_o), .spoll_data_o(spoll_data_o), .srq_o(srq_o),
    .psc_o(psc_o), .sre_o(sre_o));
  sssr_ctl_model ctl (.mclk_i(mclk_i), .cmd_ready_i(cmd_ready_o), .rsp_valid_i(rsp_valid_o),
    .spoll_valid_i(spoll_valid_o), .rsp_data_i(rsp_data_o), .spoll_data_i(spoll_data_o),
    .cmd_valid_o(cmd_valid_i), .spoll_o(spoll_i), .cmd_code_o(cmd_code_i),
    .cmd_grp_o(cmd_grp_i), .cmd_data_o(cmd_data_i));

  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // power-on with a stored flag and mask, then look at the restored mask
  task por(input logic p, input logic [7:0] s);
    rst_i = 1'b1;
    nv_psc_i = p;
    nv_sre_i = s;
    repeat (2) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 check({8'h00, sre_o}, p ? 16'h0000 : {8'h00, s});
  endtask

  // a hang counts as a mismatch
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      conclude;
    end
  end

  initial begin
    por(1'b0, 8'h28);
    {alm, ques, std, oper} = {16'h0003, 16'h0200, 16'h0024, 16'h8001};
    @(posedge mclk_i);
    #1 ques = 16'h0201;
    foreach (rows[i]) begin
      ctl.cmd(rows[i][39:36], rows[i][33:32], rows[i][31:16], r, got);
      if (rows[i][39:36] >= 4'h5) check(r, rows[i][15:0]);
    end
    mav_i = 1'b1;
    ctl.poll(b);
    check({8'h00, b}, 16'h0050);
    check({15'h0000, srq_o}, 16'h0000);
    ctl.cmd(4'h2, 2'h0, 16'h0010, r, got);
    check({15'h0000, srq_o}, 16'h0001);
    cmd_busy_i = 1'b1;
    fork
      ctl.cmd(4'h8, 2'h0, 16'h0000, r, got);
      begin
        repeat (3) @(posedge mclk_i);
        ctl.poll(b);
        check({8'h00, b}, 16'h0050);
        cmd_busy_i = 1'b0;
      end
    join
    check(r, 16'h0050);
    check({15'h0000, srq_o}, 16'h0000);
    mav_i = 1'b0;
    ctl.poll(b);
    check({8'h00, b}, 16'h0000);
    ctl.cmd(4'hf, 2'h0, 16'h0000, r, got);
    check({15'h0000, got}, 16'h0000);
    por(1'b1, 8'h28);
    conclude;
  end
endmodule // sssr_tb_top

// File: verification/sssr_top_properties.sv
`timescale 1ns/1ps
// ****************************************
// status summary checker, top ports only
// ****************************************
module sssr_props (
  input logic        mclk_i, rst_i, mav_i, cmd_busy_i, cmd_valid_i, spoll_i,
  input logic [15:0] alm_cond_i, cmd_data_i, rsp_data_o,
  input logic [3:0]  cmd_code_i,
  input logic [1:0]  cmd_grp_i,
  input logic        cmd_ready_o, rsp_valid_o, spoll_valid_o, srq_o, psc_o,
  input logic [7:0]  spoll_data_o, sre_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire cmd_take = cmd_valid_i && cmd_ready_o;  // command accepted this edge

  a_poll_answer: assert property (
    spoll_i |=> spoll_valid_o && spoll_data_o[6] == $past(srq_o)) else $error("poll answer bad");
  a_poll_zero: assert property (
    spoll_valid_o |-> !spoll_data_o[0] && !spoll_data_o[2]) else $error("unused bit set");
  a_poll_mav: assert property (
    spoll_i |=> spoll_data_o[4] == $past(mav_i)) else $error("message bit wrong");
  a_srq_cause: assert property (
    $rose(srq_o) |-> ($past(sre_o) | $past(sre_o, 2)) != 8'h00) else $error("srq without mask");
  a_read_answer: assert property (
    cmd_take && (cmd_code_i inside {4'h5, 4'h6, 4'h7, 4'h9, 4'ha}) |=> rsp_valid_o)
    else $error("read not answered");
  a_cond_read: assert property (
    cmd_take && cmd_code_i == 4'h5 && cmd_grp_i == 2'h0 |=> rsp_data_o == $past(alm_cond_i))
    else $error("condition read wrong");
  a_stb_wait: assert property (
    cmd_take && cmd_code_i == 4'h8 && cmd_busy_i |=> !rsp_valid_o && !cmd_ready_o)
    else $error("summary query did not wait");
  a_mask_write: assert property (
    !$past(rst_i) && cmd_take && cmd_code_i == 4'h2 |=> sre_o == $past(cmd_data_i[7:0]))
    else $error("mask write lost");
  a_flag_write: assert property (
    !$past(rst_i) && cmd_take && cmd_code_i == 4'h3 |=> psc_o == (|$past(cmd_data_i)))
    else $error("flag write lost");
  a_odd_code: assert property (
    cmd_take && cmd_code_i > 4'ha |=> !rsp_valid_o) else $error("unknown code answered");
endmodule // sssr_props

bind sssr_top sssr_props u_props (.mclk_i, .rst_i, .mav_i, .cmd_busy_i, .cmd_valid_i,
  .spoll_i, .alm_cond_i, .cmd_data_i, .rsp_data_o, .cmd_code_i, .cmd_grp_i, .cmd_ready_o,
  .rsp_valid_o, .spoll_valid_o, .srq_o, .psc_o, .spoll_data_o, .sre_o);
